// [hw/agc_flag_params.svh]
// Register indices, field positions, reset values and bus codes for the AGC flag block
`ifndef AGC_FLAG_PARAMS_SVH
`define AGC_FLAG_PARAMS_SVH

// ====================================================================
// Register indices (byte address is four times the index)
`define IDX_OVL_LIMIT 10'h188
`define IDX_OVL_PULSE 10'h189
`define IDX_UNSTABLE 10'h18F
`define IDX_PKA_LO 10'h193
`define IDX_PKA_HI 10'h194
`define IDX_PKB_LO 10'h195
`define IDX_PKB_HI 10'h196
`define IDX_FLOOR_LO 10'h197
`define IDX_FLOOR_HI 10'h198
`define IDX_HOLD_SIG 10'h199
`define IDX_HOLD_POW 10'h19A
`define IDX_SRC_A 10'h19B
`define IDX_SRC_B 10'h19C
`define IDX_OUT_EN 10'h19E
`define IDX_IRQ_STAT 10'h1A0
`define IDX_IRQ_MASK 10'h1A1

// ====================================================================
// Field positions
`define BIT_UNSTABLE 0
`define BIT_CLEAR 1
`define BIT_EN_A 0
`define BIT_EN_B 1
`define BIT_EN_OR 4
`define IRQ_OVERLOAD 0
`define IRQ_FLOOR 1

// ====================================================================
// Reset values
`define RST_OVL_LIMIT 3'h5
`define RST_OVL_PULSE 5'h01
`define RST_ZERO8 8'h00

// ====================================================================
// Bus codes and timing
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define OVL_WINDOW 8
`endif

// [hw/agc_flag_pkg.sv]
// Types shared by the AGC flag block
package agc_flag_pkg;
  typedef enum logic [2:0] {
    SRC_OVERLOAD = 3'h0,
    SRC_PEAK_A = 3'h4,
    SRC_PEAK_B = 3'h5,
    SRC_FLOOR = 3'h6
  } source_t;
endpackage

// [hw/agc_flag_threshold_outputs.sv]
// AGC flag generation, thresholds and pin selection behind an AXI4-Lite slave
`timescale 1ns/1ns
`include "agc_flag_params.svh"

// Summary of operation
// RULE_01: A detected overload sets the sticky instability bit, which stays set.
// RULE_02: Only the clear bit or reset clears the instability bit; reads do not.
// RULE_03: Writing one to bit 1 of the instability register clears it; bit 1 reads zero.
// RULE_04: Peak limit A is 12 bits, low byte in one register, bits 3..0 of the next on top.
// RULE_05: Peak limit B is 12 bits split the same way over the following pair.
// RULE_06: The floor limit is 12 bits, low byte plus upper nibble in the next register.
// RULE_07: The hold period is an 8-bit significand and a 4-bit power, both reset to zero.
// RULE_08: Pin three source code: 000 overload, 100 above A, 101 above B, 110 below floor.
// RULE_09: Pin four uses the same codes from its own selector, reset to 000.
// RULE_10: With bit 4 of the enable register set the overload pulse is ORed into peak flags.
// RULE_11: Enable bit 1 clear forces pin four low, set passes its chosen flag.
// RULE_12: Enable bit 0 clear forces pin three low, set passes its chosen flag.
// RULE_13: Overload is detected when more than the limit of eight samples sit at full scale.
// RULE_14: Each detection gives an overload pulse of (length plus one) times eight cycles.
// RULE_15: The floor flag rises after significand times two to the power samples below it.
// RULE_16: Reserved source codes drive the pin low.
module agc_flag_threshold_outputs
  import agc_flag_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic adc_full_scale_in,
  input wire logic peak_valid_in,
  input wire logic [11:0] peak_mag_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic gain_pin_three_out,
  output logic gain_pin_four_out,
  output logic overload_pulse_out,
  output logic irq_out
);

  // ==================================================================
  // Functions
  function automatic logic [3:0] ones8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  function automatic logic pick(input logic [2:0] sel, input logic ov,
                                input logic pa, input logic pb,
                                input logic fl, input logic orr);
    logic x;
    x = orr & ov;
    case (sel)
      SRC_OVERLOAD: pick = ov; // RULE_08
      SRC_PEAK_A: pick = pa | x; // RULE_10
      SRC_PEAK_B: pick = pb | x;
      SRC_FLOOR: pick = fl | x;
      default: pick = 1'b0; // RULE_16
    endcase
  endfunction

  function automatic logic [1:0] resp_of(input logic ok);
    return ok ? `RESP_OKAY : `RESP_SLVERR;
  endfunction

  // ==================================================================
  // Register storage
  logic [2:0] ovl_limit_q;
  logic [4:0] ovl_len_q;
  logic unstable_q;
  logic [7:0] pka_lo_q;
  logic [3:0] pka_hi_q;
  logic [7:0] pkb_lo_q;
  logic [3:0] pkb_hi_q;
  logic [7:0] floor_lo_q;
  logic [3:0] floor_hi_q;
  logic [7:0] hold_sig_q;
  logic [3:0] hold_pow_q;
  logic [2:0] src_a_q;
  logic [2:0] src_b_q;
  logic [4:0] out_en_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;

  // ==================================================================
  // AXI4-Lite write channel
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wlane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  wire aw_fire = s_axi_awvalid_in & ~aw_held_q;
  wire w_fire = s_axi_wvalid_in & ~w_held_q;
  wire wr_go = aw_held_q & w_held_q & ~bvalid_q;
  wire [9:0] wr_idx = awaddr_q[11:2];
  wire [7:0] wb = wdata_q[7:0];
  wire wr_ok;
  // Only byte lane 0 carries register data; other lanes are ignored
  wire wr_en = wr_go & wlane_q & wr_ok;

  wire we_limit = wr_en && wr_idx == `IDX_OVL_LIMIT;
  wire we_len = wr_en && wr_idx == `IDX_OVL_PULSE;
  wire we_unst = wr_en && wr_idx == `IDX_UNSTABLE;
  wire we_pka_lo = wr_en && wr_idx == `IDX_PKA_LO;
  wire we_pka_hi = wr_en && wr_idx == `IDX_PKA_HI;
  wire we_pkb_lo = wr_en && wr_idx == `IDX_PKB_LO;
  wire we_pkb_hi = wr_en && wr_idx == `IDX_PKB_HI;
  wire we_fl_lo = wr_en && wr_idx == `IDX_FLOOR_LO;
  wire we_fl_hi = wr_en && wr_idx == `IDX_FLOOR_HI;
  wire we_sig = wr_en && wr_idx == `IDX_HOLD_SIG;
  wire we_pow = wr_en && wr_idx == `IDX_HOLD_POW;
  wire we_src_a = wr_en && wr_idx == `IDX_SRC_A;
  wire we_src_b = wr_en && wr_idx == `IDX_SRC_B;
  wire we_en = wr_en && wr_idx == `IDX_OUT_EN;
  wire we_stat = wr_en && wr_idx == `IDX_IRQ_STAT;
  wire we_mask = wr_en && wr_idx == `IDX_IRQ_MASK;
  wire clear_req = we_unst & wb[`BIT_CLEAR]; // RULE_03

  assign s_axi_awready_out = ~aw_held_q;
  assign s_axi_wready_out = ~w_held_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
      end
      if (w_fire) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wlane_q <= s_axi_wstrb_in[0];
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= resp_of(wr_ok);
      end else if (bvalid_q && s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ==================================================================
  // Read decode
  logic [7:0] rd_byte;
  logic rd_hit;
  logic wr_hit;
  logic [9:0] rd_idx;
  logic arvalid_seen;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  assign rd_idx = s_axi_araddr_in[11:2];
  assign arvalid_seen = s_axi_arvalid_in & ~rvalid_q;
  assign s_axi_arready_out = ~rvalid_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  function automatic logic mapped(input logic [9:0] idx);
    case (idx)
      `IDX_OVL_LIMIT, `IDX_OVL_PULSE, `IDX_UNSTABLE, `IDX_PKA_LO, `IDX_PKA_HI,
      `IDX_PKB_LO, `IDX_PKB_HI, `IDX_FLOOR_LO, `IDX_FLOOR_HI, `IDX_HOLD_SIG,
      `IDX_HOLD_POW, `IDX_SRC_A, `IDX_SRC_B, `IDX_OUT_EN, `IDX_IRQ_STAT,
      `IDX_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  assign rd_hit = mapped(rd_idx);
  assign wr_hit = mapped(wr_idx);
  assign wr_ok = wr_hit;

  // Reading the instability register has no side effect
  always_comb begin
    case (rd_idx)
      `IDX_OVL_LIMIT: rd_byte = {5'h0, ovl_limit_q};
      `IDX_OVL_PULSE: rd_byte = {3'h0, ovl_len_q};
      `IDX_UNSTABLE: rd_byte = {7'h0, unstable_q}; // RULE_02
      `IDX_PKA_LO: rd_byte = pka_lo_q;
      `IDX_PKA_HI: rd_byte = {4'h0, pka_hi_q};
      `IDX_PKB_LO: rd_byte = pkb_lo_q;
      `IDX_PKB_HI: rd_byte = {4'h0, pkb_hi_q};
      `IDX_FLOOR_LO: rd_byte = floor_lo_q;
      `IDX_FLOOR_HI: rd_byte = {4'h0, floor_hi_q};
      `IDX_HOLD_SIG: rd_byte = hold_sig_q;
      `IDX_HOLD_POW: rd_byte = {4'h0, hold_pow_q};
      `IDX_SRC_A: rd_byte = {5'h0, src_a_q};
      `IDX_SRC_B: rd_byte = {5'h0, src_b_q};
      `IDX_OUT_EN: rd_byte = {3'h0, out_en_q};
      `IDX_IRQ_STAT: rd_byte = {6'h0, irq_stat_q};
      `IDX_IRQ_MASK: rd_byte = {6'h0, irq_mask_q};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `RESP_OKAY;
    end else if (arvalid_seen) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h0, rd_byte};
      rresp_q <= resp_of(rd_hit);
    end else if (rvalid_q && s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==================================================================
  // Configuration registers
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ovl_limit_q <= `RST_OVL_LIMIT;
      ovl_len_q <= `RST_OVL_PULSE;
      pka_lo_q <= `RST_ZERO8;
      pka_hi_q <= 4'h0;
      pkb_lo_q <= `RST_ZERO8;
      pkb_hi_q <= 4'h0;
      floor_lo_q <= `RST_ZERO8;
      floor_hi_q <= 4'h0;
      hold_sig_q <= `RST_ZERO8; // RULE_07
      hold_pow_q <= 4'h0; // RULE_07
      src_a_q <= SRC_OVERLOAD;
      src_b_q <= SRC_OVERLOAD; // RULE_09
      out_en_q <= 5'h00;
      irq_mask_q <= 2'h0;
    end else begin
      if (we_limit) ovl_limit_q <= wb[2:0];
      if (we_len) ovl_len_q <= wb[4:0];
      if (we_pka_lo) pka_lo_q <= wb; // RULE_04
      if (we_pka_hi) pka_hi_q <= wb[3:0]; // RULE_04
      if (we_pkb_lo) pkb_lo_q <= wb; // RULE_05
      if (we_pkb_hi) pkb_hi_q <= wb[3:0]; // RULE_05
      if (we_fl_lo) floor_lo_q <= wb; // RULE_06
      if (we_fl_hi) floor_hi_q <= wb[3:0]; // RULE_06
      if (we_sig) hold_sig_q <= wb;
      if (we_pow) hold_pow_q <= wb[3:0];
      if (we_src_a) src_a_q <= wb[2:0];
      if (we_src_b) src_b_q <= wb[2:0];
      if (we_en) out_en_q <= {wb[`BIT_EN_OR], 2'h0, wb[1:0]};
      if (we_mask) irq_mask_q <= wb[1:0];
    end
  end

  // ==================================================================
  // Overload detection and pulse
  logic [7:0] fs_win_q;
  logic over_q;
  logic [8:0] pulse_cnt_q;
  wire over_now = ones8(fs_win_q) > {1'b0, ovl_limit_q}; // RULE_13
  wire ovl_detect = over_now & ~over_q;
  // Counts whole groups of eight cycles; a retrigger restarts the length
  wire [8:0] pulse_load = 9'(({4'h0, ovl_len_q} + 9'h001) << 3); // RULE_14
  wire ovl_pulse = pulse_cnt_q != 9'h000;
  assign overload_pulse_out = ovl_pulse;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      fs_win_q <= 8'h00;
      over_q <= 1'b0;
      pulse_cnt_q <= 9'h000;
      unstable_q <= 1'b0;
    end else begin
      fs_win_q <= {fs_win_q[6:0], adc_full_scale_in};
      over_q <= over_now;
      if (ovl_detect) pulse_cnt_q <= pulse_load; // RULE_14
      else if (ovl_pulse) pulse_cnt_q <= pulse_cnt_q - 9'h001;
      // A detection in the clearing cycle wins
      if (ovl_detect) unstable_q <= 1'b1; // RULE_01
      else if (clear_req) unstable_q <= 1'b0; // RULE_03
    end
  end

  // ==================================================================
  // Peak comparisons and floor dwell
  wire [11:0] limit_a = {pka_hi_q, pka_lo_q}; // RULE_04
  wire [11:0] limit_b = {pkb_hi_q, pkb_lo_q}; // RULE_05
  wire [11:0] floor_lim = {floor_hi_q, floor_lo_q}; // RULE_06
  wire [22:0] dwell_target = 23'({15'h0, hold_sig_q} << hold_pow_q); // RULE_07
  logic above_a_q;
  logic above_b_q;
  logic below_q;
  logic [22:0] dwell_cnt_q;
  logic floor_q;
  wire dwell_next = peak_mag_in < floor_lim;
  wire floor_now = below_q && dwell_cnt_q >= dwell_target; // RULE_15

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      above_a_q <= 1'b0;
      above_b_q <= 1'b0;
      below_q <= 1'b0;
      dwell_cnt_q <= 23'h0;
      floor_q <= 1'b0;
    end else begin
      floor_q <= floor_now;
      if (peak_valid_in) begin
        above_a_q <= peak_mag_in > limit_a;
        above_b_q <= peak_mag_in > limit_b;
        below_q <= dwell_next;
        if (!dwell_next) dwell_cnt_q <= 23'h0; // RULE_15
        else if (dwell_cnt_q < dwell_target) dwell_cnt_q <= dwell_cnt_q + 23'h1;
      end
    end
  end

  // ==================================================================
  // Pin drive and interrupts
  logic pin_a_q;
  logic pin_b_q;
  wire or_en = out_en_q[`BIT_EN_OR];
  wire flag_a = pick(src_a_q, ovl_pulse, above_a_q, above_b_q, floor_now, or_en);
  wire flag_b = pick(src_b_q, ovl_pulse, above_a_q, above_b_q, floor_now, or_en);
  wire [1:0] irq_set = {floor_now & ~floor_q, ovl_detect};
  wire [1:0] irq_clr = we_stat ? wb[1:0] : 2'h0;
  assign gain_pin_three_out = pin_a_q;
  assign gain_pin_four_out = pin_b_q;
  assign irq_out = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
      irq_stat_q <= 2'h0;
    end else begin
      pin_a_q <= out_en_q[`BIT_EN_A] & flag_a; // RULE_12
      pin_b_q <= out_en_q[`BIT_EN_B] & flag_b; // RULE_11
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  // ==================================================================
  // Assertions
  sequence s_burst;
    ovl_pulse [*8];
  endsequence

  property p_sticky;
    @(posedge clk_sys_in) disable iff (!rstn_in) ovl_detect |=> unstable_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag not set"); // RULE_01

  property p_hold;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      unstable_q && !clear_req |=> unstable_q;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost"); // RULE_02

  property p_clear;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      clear_req && !ovl_detect |=> !unstable_q;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared"); // RULE_03

  property p_peak_a;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      peak_valid_in |=> above_a_q == $past(peak_mag_in > {pka_hi_q, pka_lo_q});
  endproperty
  a_peak_a: assert property (p_peak_a) else $error("limit A compare"); // RULE_04

  property p_peak_b;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      peak_valid_in |=> above_b_q == $past(peak_mag_in > {pkb_hi_q, pkb_lo_q});
  endproperty
  a_peak_b: assert property (p_peak_b) else $error("limit B compare"); // RULE_05

  property p_floor_break;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      peak_valid_in && peak_mag_in >= {floor_hi_q, floor_lo_q} |=> !floor_now;
  endproperty
  a_floor_break: assert property (p_floor_break) else $error("floor flag"); // RULE_15

  // Fresh crossings only: a sustained overload may legally be cleared while it lasts
  property p_detect;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      $countones(fs_win_q) > ovl_limit_q && !over_q |=> unstable_q && overload_pulse_out;
  endproperty
  a_detect: assert property (p_detect) else $error("overload missed"); // RULE_13

  property p_pulse;
    @(posedge clk_sys_in) disable iff (!rstn_in) ovl_detect |=> s_burst;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too short"); // RULE_14

  property p_en_a;
    @(posedge clk_sys_in) disable iff (!rstn_in) !out_en_q[`BIT_EN_A] |=> !pin_a_q;
  endproperty
  a_en_a: assert property (p_en_a) else $error("pin three not low"); // RULE_12

  property p_en_b;
    @(posedge clk_sys_in) disable iff (!rstn_in) !out_en_q[`BIT_EN_B] |=> !pin_b_q;
  endproperty
  a_en_b: assert property (p_en_b) else $error("pin four not low"); // RULE_11

  property p_or;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      out_en_q[`BIT_EN_A] && or_en && ovl_pulse &&
      (src_a_q == SRC_PEAK_A || src_a_q == SRC_PEAK_B || src_a_q == SRC_FLOOR) |=> pin_a_q;
  endproperty
  a_or: assert property (p_or) else $error("pulse not combined"); // RULE_10

  property p_reserved;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      src_b_q[2:1] == 2'b01 || src_b_q == 3'h7 || src_b_q == 3'h1 |=> !pin_b_q;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code"); // RULE_16

endmodule

// [verification/agc_gain_watcher.sv]
// Model of the external gain logic that watches the two flag pins
`timescale 1ns/1ns

module agc_gain_watcher (
  input wire logic clk_sys_in,
  input wire logic clear_in,
  input wire logic pin_three_in,
  input wire logic pin_four_in,
  output logic [7:0] three_high_out,
  output logic [7:0] four_high_out
);
  // ====================================================================
  // Dwell counters
  // Counts flag-high cycles, which is what a gain loop reacts to
  always_ff @(posedge clk_sys_in) begin
    if (clear_in) begin
      three_high_out <= 8'h00;
      four_high_out <= 8'h00;
    end else begin
      three_high_out <= three_high_out + {7'h00, pin_three_in};
      four_high_out <= four_high_out + {7'h00, pin_four_in};
    end
  end
endmodule

// [verification/test_agc_flag_threshold_outputs.sv]
// Self-checking bench for the AGC flag threshold and output block
`timescale 1ns/1ns
`include "agc_flag_params.svh"
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); \
  end \
end

module test_agc_flag_threshold_outputs import agc_flag_pkg::*;;
  // ====================================================================
  // Signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic afs = 1'b0;
  logic pv = 1'b0;
  logic [11:0] pm = 12'h000;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic clr = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, pin3, pin4, pulse, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] seen3, seen4;
  int err_count = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  agc_flag_threshold_outputs u_dut (
    .clk_sys_in(clk), .rstn_in(rst_n), .adc_full_scale_in(afs),
    .peak_valid_in(pv), .peak_mag_in(pm),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .gain_pin_three_out(pin3), .gain_pin_four_out(pin4),
    .overload_pulse_out(pulse), .irq_out(irq)
  );

  agc_gain_watcher u_watch (
    .clk_sys_in(clk), .clear_in(clr), .pin_three_in(pin3), .pin_four_in(pin4),
    .three_high_out(seen3), .four_high_out(seen4)
  );

  // ====================================================================
  // Bus and stimulus tasks
  // Each task ends at least one edge after its last release, so no strobe is driven twice at once
  task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    awaddr <= {i, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    `CHK("bresp", er, bresp)
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [9:0] i, input logic [7:0] e, input logic [1:0] er);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    `CHK("rdata", {24'h000000, e}, rdata)
    `CHK("rresp", er, rresp)
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // One decimated sample; pins settle one edge after it is taken
  task automatic peak(input logic [11:0] m);
    pv <= 1'b1;
    pm <= m;
    @(posedge clk);
    pv <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic trig(input int nh, input logic [7:0] ep, input logic [7:0] ea,
                      input logic [7:0] eb);
    logic [7:0] p;
    p = 8'h00;
    clr <= 1'b1;
    afs <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (nh - 1) @(posedge clk);
    afs <= 1'b0;
    repeat (60) begin
      @(posedge clk);
      p = p + {7'h00, pulse};
    end
    `CHK("pulse_cycles", ep, p)
    `CHK("pin_three_cycles", ea, seen3)
    `CHK("pin_four_cycles", eb, seen4)
  endtask

  task automatic finish_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ====================================================================
  // Tables: index, reset value, readback after writing all ones, response
  typedef struct packed {
    logic [9:0] idx;
    logic [7:0] rst;
    logic [7:0] rbk;
    logic [1:0] resp;
  } reg_row_t;
  localparam reg_row_t ROWS [15] = '{
    '{`IDX_OVL_LIMIT, 8'h05, 8'h07, `RESP_OKAY}, '{`IDX_OVL_PULSE, 8'h01, 8'h1F, `RESP_OKAY},
    '{`IDX_PKA_LO, 8'h00, 8'hFF, `RESP_OKAY}, '{`IDX_PKA_HI, 8'h00, 8'h0F, `RESP_OKAY},
    '{`IDX_PKB_LO, 8'h00, 8'hFF, `RESP_OKAY}, '{`IDX_PKB_HI, 8'h00, 8'h0F, `RESP_OKAY},
    '{`IDX_FLOOR_LO, 8'h00, 8'hFF, `RESP_OKAY}, '{`IDX_FLOOR_HI, 8'h00, 8'h0F, `RESP_OKAY},
    '{`IDX_HOLD_SIG, 8'h00, 8'hFF, `RESP_OKAY}, '{`IDX_HOLD_POW, 8'h00, 8'h0F, `RESP_OKAY},
    '{`IDX_SRC_A, 8'h00, 8'h07, `RESP_OKAY}, '{`IDX_SRC_B, 8'h00, 8'h07, `RESP_OKAY},
    '{`IDX_OUT_EN, 8'h00, 8'h13, `RESP_OKAY}, '{`IDX_UNSTABLE, 8'h00, 8'h00, `RESP_OKAY},
    '{10'h1B0, 8'h00, 8'h00, `RESP_SLVERR}
  };
  // Magnitude, expected pin three, expected pin four; limits 0x123 and 0x456 are strict
  localparam logic [13:0] PEAKS [4] = '{
    {12'h123, 2'b00}, {12'h124, 2'b10}, {12'h456, 2'b10}, {12'h457, 2'b11}
  };

  // ====================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (ROWS[k]) begin
      rchk(ROWS[k].idx, ROWS[k].rst, ROWS[k].resp);
      wr(ROWS[k].idx, 8'hFF, 4'hF, ROWS[k].resp);
      rchk(ROWS[k].idx, ROWS[k].rbk, ROWS[k].resp);
    end
    wr(`IDX_OVL_LIMIT, 8'h05, 4'hF, `RESP_OKAY);
    wr(`IDX_OVL_PULSE, 8'h01, 4'hF, `RESP_OKAY);
    wr(`IDX_SRC_A, {5'h00, SRC_OVERLOAD}, 4'hF, `RESP_OKAY);
    wr(`IDX_SRC_B, {5'h00, SRC_OVERLOAD}, 4'hF, `RESP_OKAY);
    wr(`IDX_OUT_EN, 8'h03, 4'hF, `RESP_OKAY);
    trig(5, 8'd0, 8'd0, 8'd0);
    trig(6, 8'd16, 8'd16, 8'd16);
    rchk(`IDX_UNSTABLE, 8'h01, `RESP_OKAY);
    rchk(`IDX_UNSTABLE, 8'h01, `RESP_OKAY);
    wr(`IDX_IRQ_MASK, 8'h03, 4'hF, `RESP_OKAY);
    rchk(`IDX_IRQ_STAT, 8'h01, `RESP_OKAY);
    `CHK("irq", 1'b1, irq)
    wr(`IDX_IRQ_STAT, 8'h01, 4'hF, `RESP_OKAY);
    `CHK("irq", 1'b0, irq)
    wr(`IDX_UNSTABLE, 8'h02, 4'hF, `RESP_OKAY);
    rchk(`IDX_UNSTABLE, 8'h00, `RESP_OKAY);
    // Shortest pulse, pin three off, reserved source on pin four, interrupt masked
    wr(`IDX_OVL_PULSE, 8'h00, 4'hF, `RESP_OKAY);
    wr(`IDX_OUT_EN, 8'h02, 4'hF, `RESP_OKAY);
    wr(`IDX_SRC_B, 8'h07, 4'hF, `RESP_OKAY);
    wr(`IDX_IRQ_MASK, 8'h00, 4'hF, `RESP_OKAY);
    trig(6, 8'd8, 8'd0, 8'd0);
    `CHK("irq", 1'b0, irq)
    wr(`IDX_IRQ_MASK, 8'h03, 4'hF, `RESP_OKAY);
    wr(`IDX_SRC_A, {5'h00, SRC_PEAK_A}, 4'hF, `RESP_OKAY);
    wr(`IDX_OUT_EN, 8'h11, 4'hF, `RESP_OKAY);
    trig(6, 8'd8, 8'd8, 8'd0);
    wr(`IDX_PKA_LO, 8'h23, 4'hF, `RESP_OKAY);
    wr(`IDX_PKA_HI, 8'h01, 4'hF, `RESP_OKAY);
    wr(`IDX_PKB_LO, 8'h56, 4'hF, `RESP_OKAY);
    wr(`IDX_PKB_HI, 8'h04, 4'hF, `RESP_OKAY);
    wr(`IDX_SRC_B, {5'h00, SRC_PEAK_B}, 4'hF, `RESP_OKAY);
    wr(`IDX_OUT_EN, 8'h03, 4'hF, `RESP_OKAY);
    foreach (PEAKS[k]) begin
      peak(PEAKS[k][13:2]);
      `CHK("pin_three", PEAKS[k][1], pin3)
      `CHK("pin_four", PEAKS[k][0], pin4)
    end
    // Dwell target is significand 3 shifted by power 1, so six samples
    wr(`IDX_FLOOR_LO, 8'h00, 4'hF, `RESP_OKAY);
    wr(`IDX_FLOOR_HI, 8'h02, 4'hF, `RESP_OKAY);
    wr(`IDX_HOLD_SIG, 8'h03, 4'hF, `RESP_OKAY);
    wr(`IDX_HOLD_SIG, 8'h55, 4'h0, `RESP_OKAY);
    rchk(`IDX_HOLD_SIG, 8'h03, `RESP_OKAY);
    wr(`IDX_HOLD_POW, 8'h01, 4'hF, `RESP_OKAY);
    wr(`IDX_SRC_A, {5'h00, SRC_FLOOR}, 4'hF, `RESP_OKAY);
    wr(`IDX_IRQ_STAT, 8'h03, 4'hF, `RESP_OKAY);
    peak(12'h200);
    for (int j = 0; j < 6; j++) begin
      peak(12'h1FF);
      `CHK("floor_pin", (j == 5), pin3)
    end
    peak(12'h200);
    `CHK("floor_pin", 1'b0, pin3)
    rchk(`IDX_IRQ_STAT, 8'h02, `RESP_OKAY);
    // Zero dwell target flags on the first low sample, so pin three is high into reset
    wr(`IDX_HOLD_SIG, 8'h00, 4'hF, `RESP_OKAY);
    peak(12'h1FF);
    `CHK("floor_pin", 1'b1, pin3)
    // Reset in mid-run with the instability bit set
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("pin_three", 1'b0, pin3)
    rchk(`IDX_SRC_A, 8'h00, `RESP_OKAY);
    rchk(`IDX_UNSTABLE, 8'h00, `RESP_OKAY);
    finish_test();
  end

  // Whole run is under a thousand cycles; this limit leaves ample margin
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
endmodule
